// File: core/rdc_pkg.sv
package rdc_pkg;

    // ****************************************************************
    // Register map and field layout
    // ****************************************************************
    localparam logic [31:0] REG_CONFIG_OFS    = 32'h0000001C;
    localparam logic [31:0] CONFIG_RESET      = 32'h00080000;
    localparam logic [31:0] CONFIG_WR_MASK    = 32'h00FF7F7D;
    localparam int          IQ_SEL_LSB        = 21;
    localparam int          TEST_FILT_BIT     = 20;
    localparam int          SOF_RESYNC_BIT    = 19;
    localparam int          CORR_CLR_BIT      = 18;
    localparam int          VALID_FILT_BIT    = 17;
    localparam int          DATA_EARLY_BIT    = 16;
    localparam int          SUBC_THR_LSB      = 12;
    localparam int          PHASE_THR_LSB     = 8;
    localparam int          SHORT_EVAL_BIT    = 7;
    localparam int          COLL_SEL_LSB      = 5;
    localparam int          PRE_AVG_BIT       = 4;
    localparam int          RECT_SHAPE_BIT    = 3;
    localparam int          SYNC_HIGH_BIT     = 2;
    localparam int          FSK_FLAG_BIT      = 1;
    localparam int          PHASE_SHIFT_SCHEME_SELECT_SEL_BIT      = 0;
    localparam int          AVG_GROUP         = 4;

    // I/Q channel selection
    typedef enum logic [2:0] {
        IQ_BOTH = 3'h0, IQ_I_ONLY = 3'h1, IQ_Q_ONLY = 3'h2, IQ_RSV3 = 3'h3,
        IQ_STRONGEST = 3'h4, IQ_FIRST = 3'h5, IQ_RSV6 = 3'h6, IQ_RSV7 = 3'h7
    } rdc_iq_e;

    // Collision strength select
    typedef enum logic [1:0] {
        COLL_12P5 = 2'h0, COLL_25 = 2'h1, COLL_50 = 2'h2, COLL_OFF = 2'h3
    } rdc_coll_e;

    // Decoded controls handed to the demodulator datapath
    typedef struct packed {
        logic       use_i;
        logic       use_q;
        logic       use_strongest;
        logic       use_first;
        logic       sof_equal_resync_enable;
        logic       correlator_clear_enable;
        logic       phase_validity_filter_disable;
        logic       data_before_min;
        logic       pre_average;
        logic       rectangular_shaping;
        logic       sync_high;
        logic       phase_shift_scheme_select;
        logic [1:0] collision_strength_select;
    } rdc_ctrl_s;

endpackage

// File: core/rdc_top.sv
// Operation
// - Decode I/Q select into channel usage
// - Bit 19 enables SOF equal-value resync
// - Bit 18 clears correlator on receive reset
// - Bit 17 chooses filtered or plain 0110
// - Bit 16 accepts data before first minimum
// - Bits 15:12 give subcarrier threshold
// - Table adjusts subcarrier threshold by up to three
// - Bits 11:8 give phase threshold
// - Table adjusts phase threshold by up to three
// - Read-only bit 7 picks eval length
// - Bits 6:5 pick collision strength
// - Bit 4 averages four samples
// - Bit 3 enables rectangular shaping
// - Bit 2 places grid at max/min
// - Read-only bit 1 flags FREQ_SHIFT_SCHEME_FLAG scheme
// - Writable bit 0 selects PHASE_SHIFT_SCHEME_SELECT, resets 0
// - Bits 31:24 read zero
`timescale 1ns/1ns
`default_nettype none

module rdc_top #(
    parameter int SAMPLE_W = 8
) (
    input  wire logic                 CLK,
    input  wire logic                 SYS_RST,
    input  wire logic                 HSEL,
    input  wire logic [31:0]          HADDR,
    input  wire logic [1:0]           HTRANS,
    input  wire logic                 HWRITE,
    input  wire logic [2:0]           HSIZE,
    input  wire logic [31:0]          HWDATA,
    input  wire logic                 HREADY,
    output logic      [31:0]          HRDATA,
    output logic                      HREADYOUT,
    output logic                      HRESP,
    input  wire logic                 SHORT_EVAL_IN,
    input  wire logic                 FSK_ACTIVE_IN,
    input  wire logic [2:0]           LUT_SUBC_ADJ,
    input  wire logic [2:0]           LUT_PHASE_ADJ,
    input  wire logic                 LUT_LOAD,
    input  wire logic                 RX_RESET,
    input  wire logic                 CORR_EQUAL,
    input  wire logic                 SAMPLE_VALID,
    input  wire logic [SAMPLE_W-1:0]  SAMPLE_IN,
    output logic                      SAMPLE_OUT_VALID,
    output logic      [SAMPLE_W-1:0]  SAMPLE_OUT,
    output logic                      CORR_CLEAR,
    output logic                      SOF_RESYNC,
    output logic      [3:0]           SUBC_THRESHOLD,
    output logic      [3:0]           PHASE_THRESHOLD,
    output rdc_pkg::rdc_ctrl_s        CTRL
);

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    logic        cfg_wr_ff, nxt_cfg_wr;
    logic        rd_ok_ff;
    logic [31:0] cfg_ff;
    logic        short_eval_ff;
    logic        fsk_ff;

    // Address phase decode; writes of any HSIZE to the one register land
    wire addr_ok  = HADDR == rdc_pkg::REG_CONFIG_OFS;
    wire take     = HSEL && HREADY && HTRANS[1];
    assign nxt_cfg_wr = take && HWRITE && addr_ok;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg_wr_ff <= 1'b0;
            rd_ok_ff  <= 1'b0;
        end else begin
            cfg_wr_ff <= nxt_cfg_wr;
            rd_ok_ff  <= take && !HWRITE && addr_ok;
        end
    end

    // Zero wait states and always OKAY keeps the slave trivially simple
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    // ****************************************************************
    // Configuration register
    // ****************************************************************
    // Status inputs sampled from the same clock domain
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            short_eval_ff <= 1'b0;
            fsk_ff        <= 1'b0;
        end else begin
            short_eval_ff <= SHORT_EVAL_IN;
            fsk_ff        <= FSK_ACTIVE_IN;
        end
    end

    // Relative table adjust: sign-magnitude step, saturated at 0 and 15
    function automatic logic [3:0] adj4(input logic [3:0] cur, input logic [2:0] d);
        logic [4:0] sum;
        sum = 5'h00;
        if (d[2]) begin
            sum = {1'b0, cur} - {3'h0, d[1:0]};
            adj4 = sum[4] ? 4'h0 : sum[3:0];
        end else begin
            sum = {1'b0, cur} + {3'h0, d[1:0]};
            adj4 = sum[4] ? 4'hF : sum[3:0];
        end
    endfunction

    wire [3:0] subc_adj  = adj4(cfg_ff[rdc_pkg::SUBC_THR_LSB +: 4], LUT_SUBC_ADJ);
    wire [3:0] phase_adj = adj4(cfg_ff[rdc_pkg::PHASE_THR_LSB +: 4], LUT_PHASE_ADJ);
    wire [31:0] wr_val   = (HWDATA & rdc_pkg::CONFIG_WR_MASK)
                         | (cfg_ff & ~rdc_pkg::CONFIG_WR_MASK);

    // Bus write wins over a table load arriving in the same cycle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg_ff <= rdc_pkg::CONFIG_RESET;
        end else if (cfg_wr_ff) begin
            cfg_ff <= wr_val;
        end else if (LUT_LOAD) begin
            cfg_ff[rdc_pkg::SUBC_THR_LSB +: 4]  <= subc_adj;
            cfg_ff[rdc_pkg::PHASE_THR_LSB +: 4] <= phase_adj;
        end
    end

    // Read view: reserved high byte zero, read-only bits from live status
    wire [31:0] rd_view = {8'h00, cfg_ff[23:8], short_eval_ff, cfg_ff[6:2],
                           fsk_ff, cfg_ff[0]};

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            HRDATA <= 32'h00000000;
        end else begin
            HRDATA <= (take && !HWRITE && addr_ok) ? rd_view : 32'h00000000;
        end
    end

    // ****************************************************************
    // Decoded controls
    // ****************************************************************
    rdc_pkg::rdc_iq_e iq_sel;
    rdc_pkg::rdc_ctrl_s nxt_ctrl;
    assign iq_sel = rdc_pkg::rdc_iq_e'(cfg_ff[rdc_pkg::IQ_SEL_LSB +: 3]);

    // Reserved I/Q codes fall back to using neither channel
    always_comb begin
        nxt_ctrl = '0;
        unique case (iq_sel)
            rdc_pkg::IQ_BOTH:      begin nxt_ctrl.use_i = 1'b1; nxt_ctrl.use_q = 1'b1; end
            rdc_pkg::IQ_I_ONLY:    nxt_ctrl.use_i = 1'b1;
            rdc_pkg::IQ_Q_ONLY:    nxt_ctrl.use_q = 1'b1;
            rdc_pkg::IQ_STRONGEST: nxt_ctrl.use_strongest = 1'b1;
            rdc_pkg::IQ_FIRST:     nxt_ctrl.use_first = 1'b1;
            default:               nxt_ctrl.use_i = 1'b0;
        endcase
        nxt_ctrl.sof_equal_resync_enable       = cfg_ff[rdc_pkg::SOF_RESYNC_BIT];
        nxt_ctrl.correlator_clear_enable       = cfg_ff[rdc_pkg::CORR_CLR_BIT];
        nxt_ctrl.phase_validity_filter_disable = cfg_ff[rdc_pkg::VALID_FILT_BIT];
        nxt_ctrl.data_before_min               = cfg_ff[rdc_pkg::DATA_EARLY_BIT];
        nxt_ctrl.pre_average                   = cfg_ff[rdc_pkg::PRE_AVG_BIT];
        nxt_ctrl.rectangular_shaping           = cfg_ff[rdc_pkg::RECT_SHAPE_BIT];
        nxt_ctrl.sync_high                     = cfg_ff[rdc_pkg::SYNC_HIGH_BIT];
        nxt_ctrl.phase_shift_scheme_select     = cfg_ff[rdc_pkg::PHASE_SHIFT_SCHEME_SELECT_SEL_BIT];
        nxt_ctrl.collision_strength_select     = cfg_ff[rdc_pkg::COLL_SEL_LSB +: 2];
    end

    // Controls and thresholds are registered so every output is a flop
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            CTRL            <= '0;
            SUBC_THRESHOLD  <= 4'h0;
            PHASE_THRESHOLD <= 4'h0;
            CORR_CLEAR      <= 1'b0;
            SOF_RESYNC      <= 1'b0;
        end else begin
            CTRL            <= nxt_ctrl;
            SUBC_THRESHOLD  <= cfg_ff[rdc_pkg::SUBC_THR_LSB +: 4];
            PHASE_THRESHOLD <= cfg_ff[rdc_pkg::PHASE_THR_LSB +: 4];
            CORR_CLEAR      <= RX_RESET && cfg_ff[rdc_pkg::CORR_CLR_BIT];
            SOF_RESYNC      <= CORR_EQUAL && cfg_ff[rdc_pkg::SOF_RESYNC_BIT];
        end
    end

    // ****************************************************************
    // Sample pre-averaging
    // ****************************************************************
    logic [SAMPLE_W+1:0] acc_ff;
    logic [1:0]          cnt_ff;
    wire  [SAMPLE_W+1:0] acc_sum = acc_ff + {2'b00, SAMPLE_IN};
    wire                 grp_end = cnt_ff == 2'(rdc_pkg::AVG_GROUP - 1);

    // Averaging trades sample rate for noise; RX_RESET restarts a group
    always_ff @(posedge CLK) begin
        if (SYS_RST || RX_RESET) begin
            acc_ff           <= '0;
            cnt_ff           <= 2'h0;
            SAMPLE_OUT_VALID <= 1'b0;
            SAMPLE_OUT       <= '0;
        end else if (!SAMPLE_VALID) begin
            SAMPLE_OUT_VALID <= 1'b0;
        end else if (!cfg_ff[rdc_pkg::PRE_AVG_BIT]) begin
            SAMPLE_OUT_VALID <= 1'b1;
            SAMPLE_OUT       <= SAMPLE_IN;
            cnt_ff           <= 2'h0;
            acc_ff           <= '0;
        end else if (grp_end) begin
            SAMPLE_OUT_VALID <= 1'b1;
            SAMPLE_OUT       <= acc_sum[SAMPLE_W+1:2];
            cnt_ff           <= 2'h0;
            acc_ff           <= '0;
        end else begin
            SAMPLE_OUT_VALID <= 1'b0;
            cnt_ff           <= cnt_ff + 2'h1;
            acc_ff           <= acc_sum;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_reserved_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
        HRDATA[31:24] == 8'h00) else $error("reserved bits read nonzero");
    chk_ro_unchanged: assert property (@(posedge CLK) disable iff (SYS_RST)
        cfg_wr_ff |=> (cfg_ff[7] == $past(cfg_ff[7]) && cfg_ff[1] == $past(cfg_ff[1])))
        else $error("read-only bit changed on write");
    chk_corr_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
        (RX_RESET && cfg_ff[18]) |=> CORR_CLEAR) else $error("correlator clear missed");
    chk_resync_gate: assert property (@(posedge CLK) disable iff (SYS_RST)
        SOF_RESYNC |-> $past(CORR_EQUAL && cfg_ff[19])) else $error("resync without cause");
    chk_fsk_reads: assert property (@(posedge CLK) disable iff (SYS_RST)
        (take && !HWRITE && addr_ok) |=> HRDATA[1] == $past(fsk_ff)) else $error("fsk flag mismatch");
    chk_eval_reads: assert property (@(posedge CLK) disable iff (SYS_RST)
        (take && !HWRITE && addr_ok) |=> HRDATA[7] == $past(short_eval_ff))
        else $error("eval bit mismatch");
    chk_phase_shift_scheme_select_write: assert property (@(posedge CLK) disable iff (SYS_RST)
        nxt_cfg_wr |=> ##2 CTRL.phase_shift_scheme_select == $past(HWDATA[0], 2))
        else $error("phase_shift_scheme_select select not written");
    chk_subc_thr: assert property (@(posedge CLK) disable iff (SYS_RST)
        SUBC_THRESHOLD == $past(cfg_ff[15:12])) else $error("subcarrier threshold wrong");
    chk_phase_thr: assert property (@(posedge CLK) disable iff (SYS_RST)
        PHASE_THRESHOLD == $past(cfg_ff[11:8])) else $error("phase threshold wrong");
    chk_subc_step: assert property (@(posedge CLK) disable iff (SYS_RST)
        (LUT_LOAD && !cfg_wr_ff && !LUT_SUBC_ADJ[2] && cfg_ff[15:12] < 4'hC)
        |=> cfg_ff[15:12] == $past(cfg_ff[15:12]) + {2'b00, $past(LUT_SUBC_ADJ[1:0])})
        else $error("subcarrier adjust wrong");
    chk_coll_sel: assert property (@(posedge CLK) disable iff (SYS_RST)
        CTRL.collision_strength_select == $past(cfg_ff[6:5])) else $error("collision select wrong");

    // ****************************************************************
    // Bus checks
    // ****************************************************************
    // The master waits on ready, so a low ready here would hang the bus
    chk_ready_high: assert property (@(posedge CLK) disable iff (SYS_RST)
        HREADYOUT)
        else $error("ready dropped");
    // Error responses are never produced by this slave
    chk_resp_okay: assert property (@(posedge CLK) disable iff (SYS_RST)
        !HRESP)
        else $error("response not okay");
    // Read data stays zero outside a decoded read data phase
    chk_rd_idle_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
        !(take && !HWRITE && addr_ok)
        |=> HRDATA == 32'h00000000)
        else $error("read data outside data phase");
    // Every writable bit takes the data phase word
    chk_write_lands: assert property (@(posedge CLK) disable iff (SYS_RST)
        cfg_wr_ff
        |=> (cfg_ff & rdc_pkg::CONFIG_WR_MASK) == ($past(HWDATA) & rdc_pkg::CONFIG_WR_MASK))
        else $error("write did not land");

    // ****************************************************************
    // Field checks
    // ****************************************************************
    // Each control bit follows its register bit one cycle later
    chk_sync_high: assert property (@(posedge CLK) disable iff (SYS_RST)
        CTRL.sync_high == $past(cfg_ff[2]))
        else $error("grid placement wrong");
    chk_rect_shape: assert property (@(posedge CLK) disable iff (SYS_RST)
        CTRL.rectangular_shaping == $past(cfg_ff[3]))
        else $error("shaping select wrong");
    chk_data_early: assert property (@(posedge CLK) disable iff (SYS_RST)
        CTRL.data_before_min == $past(cfg_ff[16]))
        else $error("early data select wrong");
    chk_valid_filt: assert property (@(posedge CLK) disable iff (SYS_RST)
        CTRL.phase_validity_filter_disable == $past(cfg_ff[17]))
        else $error("validity filter select wrong");
    // Both channels for code zero, none for reserved codes
    chk_iq_both: assert property (@(posedge CLK) disable iff (SYS_RST)
        cfg_ff[23:21] == 3'h0
        |=> CTRL.use_i && CTRL.use_q && !CTRL.use_strongest && !CTRL.use_first)
        else $error("both channels not selected");
    chk_iq_reserved: assert property (@(posedge CLK) disable iff (SYS_RST)
        (cfg_ff[23:21] inside {3'h3, 3'h6, 3'h7})
        |=> !CTRL.use_i && !CTRL.use_q && !CTRL.use_strongest && !CTRL.use_first)
        else $error("reserved channel code used");
    // Event outputs fire exactly when their enable allows
    chk_resync_fire: assert property (@(posedge CLK) disable iff (SYS_RST)
        (CORR_EQUAL && cfg_ff[19])
        |=> SOF_RESYNC)
        else $error("resync missed");
    chk_clear_quiet: assert property (@(posedge CLK) disable iff (SYS_RST)
        !cfg_ff[18]
        |=> !CORR_CLEAR)
        else $error("clear while disabled");

    // ****************************************************************
    // Table checks
    // ****************************************************************
    // Negative steps must floor at zero rather than wrap to a high level
    chk_phase_step: assert property (@(posedge CLK) disable iff (SYS_RST)
        (LUT_LOAD && !cfg_wr_ff && LUT_PHASE_ADJ[2] && cfg_ff[11:8] > 4'h2)
        |=> cfg_ff[11:8] == $past(cfg_ff[11:8]) - {2'b00, $past(LUT_PHASE_ADJ[1:0])})
        else $error("phase adjust wrong");
    chk_subc_floor: assert property (@(posedge CLK) disable iff (SYS_RST)
        (LUT_LOAD && !cfg_wr_ff && LUT_SUBC_ADJ[2] && cfg_ff[15:12] < {2'b00, LUT_SUBC_ADJ[1:0]})
        |=> cfg_ff[15:12] == 4'h0)
        else $error("subcarrier floor wrong");
    chk_phase_ceiling: assert property (@(posedge CLK) disable iff (SYS_RST)
        (LUT_LOAD && !cfg_wr_ff && !LUT_PHASE_ADJ[2]
         && ({1'b0, cfg_ff[11:8]} + {3'h0, LUT_PHASE_ADJ[1:0]}) > 5'h0F)
        |=> cfg_ff[11:8] == 4'hF)
        else $error("phase ceiling wrong");

    // ****************************************************************
    // Sample checks
    // ****************************************************************
    // Mid-group samples are swallowed while averaging
    chk_avg_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
        (SAMPLE_VALID && cfg_ff[4] && !grp_end && !RX_RESET)
        |=> !SAMPLE_OUT_VALID)
        else $error("output inside a group");
    // Without averaging each sample passes one cycle late
    chk_pass_through: assert property (@(posedge CLK) disable iff (SYS_RST)
        (SAMPLE_VALID && !cfg_ff[4] && !RX_RESET)
        |=> SAMPLE_OUT_VALID && SAMPLE_OUT == $past(SAMPLE_IN))
        else $error("pass-through sample wrong");

endmodule

`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;

    // ****************************************************************
    // Bench signals and the block
    // ****************************************************************
    localparam logic [31:0] OFS = 32'h0000001C;
    logic              clk, sys_rst, hsel, hwrite, short_eval, fsk_active;
    logic              lut_load, rx_reset, corr_equal, s_valid;
    logic [31:0]       haddr, hwdata;
    logic [1:0]        htrans;
    logic [2:0]        hsize, adj_subc, adj_phase;
    logic [7:0]        s_in;
    wire logic [31:0]  hrdata;
    wire logic         hreadyout, hresp, so_valid, corr_clear, sof_resync, hready;
    wire logic [7:0]   s_out;
    wire logic [3:0]   subc_thr, phase_thr;
    rdc_pkg::rdc_ctrl_s ctrl;
    int                n_fail, checks;
    // One slave on the bus, so its ready is the bus ready
    assign hready = hreadyout;

    rdc_top #(.SAMPLE_W(8)) dut (
        .CLK(clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .SHORT_EVAL_IN(short_eval), .FSK_ACTIVE_IN(fsk_active), .LUT_SUBC_ADJ(adj_subc),
        .LUT_PHASE_ADJ(adj_phase), .LUT_LOAD(lut_load), .RX_RESET(rx_reset),
        .CORR_EQUAL(corr_equal), .SAMPLE_VALID(s_valid), .SAMPLE_IN(s_in),
        .SAMPLE_OUT_VALID(so_valid), .SAMPLE_OUT(s_out), .CORR_CLEAR(corr_clear),
        .SOF_RESYNC(sof_resync), .SUBC_THRESHOLD(subc_thr), .PHASE_THRESHOLD(phase_thr),
        .CTRL(ctrl)
    );

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic wrap_up();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Bounded wait for ready; a hung slave ends the run
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 20) begin
                `CHK(hready, 1'b1)
                wrap_up();
            end
            @(posedge clk);
        end
    endtask

    // One single word transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        xfer(1'b0, a, 32'h00000000, x);
        `CHK(x, e)
    endtask

    // Both event inputs together; each output follows its enable bit
    task automatic pulse_chk(input logic e);
        rx_reset <= 1'b1;
        corr_equal <= 1'b1;
        @(posedge clk);
        rx_reset <= 1'b0;
        corr_equal <= 1'b0;
        @(posedge clk);
        `CHK(corr_clear, e)
        `CHK(sof_resync, e)
    endtask

    // Relative table step applied to both thresholds
    task automatic lut_step(input logic [2:0] s, input logic [2:0] p, input logic [7:0] e);
        adj_subc <= s;
        adj_phase <= p;
        lut_load <= 1'b1;
        @(posedge clk);
        lut_load <= 1'b0;
        tick(3);
        `CHK({subc_thr, phase_thr}, e)
    endtask

    // Main sequence; reserved IQ codes give no channel flags
    initial begin
        static logic [3:0] iq_tab [8] = '{4'hC, 4'h8, 4'h4, 4'h0, 4'h2, 4'h1, 4'h0, 4'h0};
        static logic [7:0] smp [4] = '{8'h0A, 8'h14, 8'h1E, 8'h29};
        logic [2:0]  c;
        logic [31:0] v;
        logic [7:0]  got;
        int          nv;
        {sys_rst, hsel, hwrite, short_eval, fsk_active, lut_load} = 6'h20;
        {rx_reset, corr_equal, s_valid, htrans, hsize, adj_subc, adj_phase} = 14'h0000;
        {haddr, hwdata, s_in} = 72'h0;
        n_fail = 0;
        checks = 0;
        got = 8'h00;
        tick(16);
        sys_rst <= 1'b0;
        rd_chk(OFS, 32'h00080000);
        wr(OFS, 32'hFFFFFFFF);
        rd_chk(OFS, 32'h00FF7F7D);
        short_eval <= 1'b1;
        fsk_active <= 1'b1;
        tick(3);
        rd_chk(OFS, 32'h00FF7FFF);
        wr(OFS, 32'h00000000);
        rd_chk(OFS, 32'h00000082);
        wr(32'h00000020, 32'hFFFFFFFF);
        rd_chk(32'h00000020, 32'h00000000);
        rd_chk(OFS, 32'h00000082);
        short_eval <= 1'b0;
        fsk_active <= 1'b0;
        $display("test regmap done");
        pulse_chk(1'b0);
        wr(OFS, 32'h000C0000);
        tick(2);
        pulse_chk(1'b1);
        $display("test events done");
        wr(OFS, 32'h00005E00);
        tick(3);
        `CHK({subc_thr, phase_thr}, 8'h5E)
        lut_step(3'b011, 3'b011, 8'h8F);
        lut_step(3'b111, 3'b110, 8'h5D);
        rd_chk(OFS, 32'h00005D00);
        $display("test thresholds done");
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            v = {8'h00, c, 1'b0, c[2], c[1], c[0], c[1], 8'h00, 1'b0, c[1:0], c[0], c[1],
                 c[2], 1'b0, c[0]};
            wr(OFS, v);
            tick(3);
            `CHK(ctrl, {iq_tab[i], c[2], c[1], c[0], c[1], c[0], c[1], c[2], c[0], c[1:0]})
            rd_chk(OFS, v);
        end
        $display("test decode done");
        wr(OFS, 32'h00000000);
        tick(2);
        s_valid <= 1'b1;
        s_in <= 8'h5A;
        @(posedge clk);
        s_valid <= 1'b0;
        @(posedge clk);
        `CHK({so_valid, s_out}, 9'h15A)
        wr(OFS, 32'h00000010);
        tick(2);
        rx_reset <= 1'b1;
        @(posedge clk);
        rx_reset <= 1'b0;
        @(posedge clk);
        nv = 0;
        for (int i = 0; i < 10; i++) begin
            s_valid <= (i < 4);
            s_in <= smp[i % 4];
            @(posedge clk);
            if (so_valid === 1'b1) begin
                nv++;
                got = s_out;
            end
        end
        `CHK(nv, 1)
        `CHK(got, 8'h19)
        $display("test averaging done");
        wrap_up();
    end

endmodule

`default_nettype wire
